// [hdl/dpss_top.v]
`timescale 1ns/1ps
`include "dpss_regs.vh"

// Overview of operation
// - A 0-to-1 change of select bit 0 picks gain bank 1 and a 1-to-0 change picks gain bank 0.
// - A 0-to-1 change of select bit 1 picks limiter bank 1 and a 1-to-0 change picks limiter bank 0.
// - A 0-to-1 change of select bit 2 picks modifier bank 1 and a 1-to-0 change picks modifier bank 0.
// - Select bits 3 to 15 read as zero and software writes them only as zero.
// - A write of the flag word sets each of the sixteen user flags, bit n to flag n.
// - Any user flag can be routed to a digital output that follows it.
module dpss_top #(
   parameter NFLAG = 16
) (
   input wire clk,
   input wire arst_n,
   input wire [`DPSS_ADDR_W-1:0] addr,
   input wire [`DPSS_DATA_W-1:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   output reg [`DPSS_DATA_W-1:0] rdata_ff,
   output reg gain_bank_ff,
   output reg limit_bank_ff,
   output reg modif_bank_ff,
   output reg [NFLAG-1:0] user_flag_ff,
   output reg [NFLAG-1:0] dout_ff
);
   // ****************************************
   // Reset release
   // ****************************************
   reg rst_s1_ff;
   reg rst_n_ff;
   // Assert asynchronously, release on clock to avoid recovery hazards
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_n_ff <= rst_s1_ff;
      end
   end

   // ****************************************
   // Register writes
   // ****************************************
   reg [`DPSS_DATA_W-1:0] bank_sel_ff;
   reg [`DPSS_DATA_W-1:0] out_route_ff;
   wire wr_bank;
   wire wr_flag;
   wire wr_route;
   wire [`DPSS_DATA_W-1:0] nxt_bank_sel;
   assign wr_bank = wr_stb & (addr == `DPSS_OFF_BANK_SEL);
   assign wr_flag = wr_stb & (addr == `DPSS_OFF_USER_FLAG);
   assign wr_route = wr_stb & (addr == `DPSS_OFF_OUT_ROUTE);
   // Reserved bits forced to zero even if the master breaks its side
   assign nxt_bank_sel = wdata & `DPSS_BANK_SEL_MASK;

   // Stored select word, the reference for edge detection
   always @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         bank_sel_ff <= `DPSS_RST_BANK_SEL;
         user_flag_ff <= `DPSS_RST_USER_FLAG;
         out_route_ff <= `DPSS_RST_OUT_ROUTE;
      end else begin
         if (wr_bank) begin
            bank_sel_ff <= nxt_bank_sel;
         end
         if (wr_flag) begin
            user_flag_ff <= wdata[NFLAG-1:0];
         end
         if (wr_route) begin
            out_route_ff <= wdata;
         end
      end
   end

   // ****************************************
   // Bank selectors
   // ****************************************
   wire gain_bank;
   wire limit_bank;
   wire modif_bank;
   dpss_bank_edge u_gain (
      .clk(clk),
      .rst_n(rst_n_ff),
      .wr_en(wr_bank),
      .new_bit(nxt_bank_sel[`DPSS_BIT_GAIN]),
      .old_bit(bank_sel_ff[`DPSS_BIT_GAIN]),
      .bank_ff(gain_bank)
   );
   dpss_bank_edge u_limit (
      .clk(clk),
      .rst_n(rst_n_ff),
      .wr_en(wr_bank),
      .new_bit(nxt_bank_sel[`DPSS_BIT_LIMIT]),
      .old_bit(bank_sel_ff[`DPSS_BIT_LIMIT]),
      .bank_ff(limit_bank)
   );
   dpss_bank_edge u_modif (
      .clk(clk),
      .rst_n(rst_n_ff),
      .wr_en(wr_bank),
      .new_bit(nxt_bank_sel[`DPSS_BIT_MODIF]),
      .old_bit(bank_sel_ff[`DPSS_BIT_MODIF]),
      .bank_ff(modif_bank)
   );

   // ****************************************
   // Outputs
   // ****************************************
   // Bank outputs registered once more so every top output is a flop
   always @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         gain_bank_ff <= `DPSS_RST_BANK;
         limit_bank_ff <= `DPSS_RST_BANK;
         modif_bank_ff <= `DPSS_RST_BANK;
         dout_ff <= {NFLAG{1'b0}};
      end else begin
         gain_bank_ff <= gain_bank;
         limit_bank_ff <= limit_bank;
         modif_bank_ff <= modif_bank;
         dout_ff <= user_flag_ff & out_route_ff[NFLAG-1:0];
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   reg [`DPSS_DATA_W-1:0] nxt_rdata;
   // Unmapped addresses read zero
   always @* begin
      nxt_rdata = {`DPSS_DATA_W{1'b0}};
      case (addr)
         `DPSS_OFF_BANK_SEL: nxt_rdata = bank_sel_ff;
         `DPSS_OFF_USER_FLAG: nxt_rdata = user_flag_ff;
         `DPSS_OFF_BANK_STAT: nxt_rdata = {13'h0000, modif_bank, limit_bank, gain_bank};
         `DPSS_OFF_OUT_ROUTE: nxt_rdata = out_route_ff;
         `DPSS_OFF_OUT_STAT: nxt_rdata = dout_ff;
         default: nxt_rdata = {`DPSS_DATA_W{1'b0}};
      endcase
   end

   // Data valid only in the cycle after the strobe, zero otherwise
   always @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         rdata_ff <= {`DPSS_DATA_W{1'b0}};
      end else if (rd_stb) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= {`DPSS_DATA_W{1'b0}};
      end
   end
endmodule // dpss_top

// [common/dpss_regs.vh]
`ifndef DPSS_REGS_VH
`define DPSS_REGS_VH
// ****************************************
// Register map (word index == address)
// ****************************************
`define DPSS_ADDR_W 4
`define DPSS_DATA_W 16
`define DPSS_OFF_BANK_SEL 4'h2
`define DPSS_OFF_USER_FLAG 4'h3
`define DPSS_OFF_BANK_STAT 4'h4
`define DPSS_OFF_OUT_ROUTE 4'h5
`define DPSS_OFF_OUT_STAT 4'h6
// ****************************************
// Field positions
// ****************************************
`define DPSS_BIT_GAIN 0
`define DPSS_BIT_LIMIT 1
`define DPSS_BIT_MODIF 2
`define DPSS_BANK_SEL_MASK 16'h0007
// ****************************************
// Reset values
// ****************************************
`define DPSS_RST_BANK_SEL 16'h0000
`define DPSS_RST_USER_FLAG 16'h0000
`define DPSS_RST_OUT_ROUTE 16'h0000
`define DPSS_RST_BANK 1'b0
`endif

// [hdl/dpss_bank_edge.v]
`timescale 1ns/1ps
`include "dpss_regs.vh"
// ****************************************
// One bank selector, driven by transitions of its control bit
// ****************************************
module dpss_bank_edge (
   input wire clk,
   input wire rst_n,
   input wire wr_en,
   input wire new_bit,
   input wire old_bit,
   output reg bank_ff
);
   wire rise;
   wire fall;
   // Only a change versus the stored copy counts; rewrites are ignored
   assign rise = wr_en & new_bit & ~old_bit;
   assign fall = wr_en & ~new_bit & old_bit;
   // Bank follows edges, so a forced bank elsewhere is never overridden by a rewrite
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_ff <= `DPSS_RST_BANK;
      end else if (rise) begin
         bank_ff <= 1'b1;
      end else if (fall) begin
         bank_ff <= 1'b0;
      end
   end
endmodule // dpss_bank_edge

// [tb/dpss_master.sv]
`timescale 1ns/1ps
// ****
// Master model
// ****
module dpss_master (
   input wire clk,
   output reg [3:0] addr,
   output reg [15:0] wdata,
   output reg wr_stb,
   output reg rd_stb,
   input wire [15:0] rdata_ff
);
   // Idle bus from time zero
   initial {addr, wdata, wr_stb, rd_stb} = 22'h0;
   // One-cycle write strobe
   task wr(input [3:0] a, input [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= (a == 4'h2) ? (v & 16'h0007) : v; // Reserved select bits sent as zero
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task rd(input [3:0] a, output [15:0] v);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      v = rdata_ff;
   endtask
endmodule // dpss_master

// [tb/dpss_monitor.sv]
`timescale 1ns/1ps
// ****
// Checker
// ****
module dpss_monitor #(parameter NFLAG = 16) (
   input wire clk,
   input wire arst_n,
   input wire [3:0] addr,
   input wire [15:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   input wire [15:0] rdata_ff,
   input wire gain_bank_ff,
   input wire limit_bank_ff,
   input wire modif_bank_ff,
   input wire [NFLAG-1:0] user_flag_ff,
   input wire [NFLAG-1:0] dout_ff
);
   reg [2:0] sel_ff;
   reg [15:0] uf_ff, rt_ff;
   wire [2:0] bk = {modif_bank_ff, limit_bank_ff, gain_bank_ff};
   // Own shadow of the writes, so checks never lean on the design
   always @(posedge clk or negedge arst_n)
      if (!arst_n) {sel_ff, uf_ff, rt_ff} <= 35'h0;
      else if (wr_stb) begin
         if (addr == 4'h2) sel_ff <= wdata[2:0];
         if (addr == 4'h3) uf_ff <= wdata;
         if (addr == 4'h5) rt_ff <= wdata;
      end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Select write is the first step; bank pins follow two edges later
   sequence s_sel_wr;
      wr_stb && addr == 4'h2;
   endsequence
   property p_gain; s_sel_wr |-> ##2 bk[0] == $past(wdata[0], 2); endproperty
   a_gain: assert property (p_gain) else $error("gain bank");
   property p_lim; s_sel_wr |-> ##2 bk[1] == $past(wdata[1], 2); endproperty
   a_lim: assert property (p_lim) else $error("limit bank");
   property p_mod; s_sel_wr |-> ##2 bk[2] == $past(wdata[2], 2); endproperty
   a_mod: assert property (p_mod) else $error("modifier bank");
   property p_rsv; rd_stb && addr == 4'h2 |=> rdata_ff == {13'h0, $past(sel_ff)}; endproperty
   a_rsv: assert property (p_rsv) else $error("select readback");
   property p_flag; wr_stb && addr == 4'h3 |=> user_flag_ff == $past(wdata); endproperty
   a_flag: assert property (p_flag) else $error("flag word");
   property p_pol; user_flag_ff == uf_ff; endproperty
   a_pol: assert property (p_pol) else $error("flag level");
   property p_out; dout_ff == $past(uf_ff & rt_ff); endproperty
   a_out: assert property (p_out) else $error("output pins");
   property p_same; s_sel_wr ##0 (wdata[2:0] == sel_ff) |-> ##2 $stable(bk); endproperty
   a_same: assert property (p_same) else $error("bank on rewrite");
endmodule // dpss_monitor
bind dpss_top dpss_monitor #(.NFLAG(NFLAG)) mon (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff), .gain_bank_ff(gain_bank_ff), .limit_bank_ff(limit_bank_ff),
   .modif_bank_ff(modif_bank_ff), .user_flag_ff(user_flag_ff), .dout_ff(dout_ff));

// [tb/test_drive_param_set_select_and_user_outputs.sv]
`timescale 1ns/1ps
// ****
// Bench
// ****
module test_drive_param_set_select_and_user_outputs;
   reg clk = 1'b0;
   reg arst_n = 1'b0;
   wire [3:0] addr;
   wire [15:0] wdata, rdata_ff, user_flag_ff, dout_ff;
   wire wr_stb, rd_stb, gain_bank_ff, limit_bank_ff, modif_bank_ff;
   integer mismatches = 0, comparisons = 0, i;
   reg [15:0] d;
   // Select values 1,1,3,7,6,6,0,5: repeats exercise rewrites
   localparam [23:0] SEQ = 24'ha36ec9;
   initial forever #20 clk = ~clk;
   dpss_master m (.clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff));
   dpss_top dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata_ff(rdata_ff), .gain_bank_ff(gain_bank_ff), .limit_bank_ff(limit_bank_ff),
      .modif_bank_ff(modif_bank_ff), .user_flag_ff(user_flag_ff), .dout_ff(dout_ff));
   task chk(input string n, input [15:0] s, input [15:0] e);
      comparisons = comparisons + 1;
      if (s !== e) begin
         mismatches = mismatches + 1;
         $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Main sequence; every wait is a fixed count from the hand-over timing
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      m.rd(4'h3, d);
      chk("flags", d, 16'h0);
      for (i = 0; i < 8; i = i + 1) begin
         m.wr(4'h2, {13'h0, SEQ[i*3+:3]});
         @(posedge clk);
         @(negedge clk);
         chk("bank", {13'h0, modif_bank_ff, limit_bank_ff, gain_bank_ff}, {13'h0, SEQ[i*3+:3]});
         m.rd(4'h2, d);
         chk("sel", d, {13'h0, SEQ[i*3+:3]});
         m.rd(4'h4, d);
         chk("stat", d, {13'h0, SEQ[i*3+:3]});
      end
      $display("bank test done");
      m.wr(4'h3, 16'ha5c3);
      m.wr(4'h5, 16'h0ff0);
      m.rd(4'h6, d);
      chk("dout", d, 16'h05c0);
      chk("pins", dout_ff, 16'h05c0);
      chk("flag", user_flag_ff, 16'ha5c3);
      m.rd(4'h5, d);
      chk("route", d, 16'h0ff0);
      m.rd(4'h3, d);
      chk("flagrd", d, 16'ha5c3);
      m.wr(4'h0, 16'hffff);
      m.rd(4'h0, d);
      chk("hole", d, 16'h0);
      $display("flag test done");
      final_report;
   end
endmodule // test_drive_param_set_select_and_user_outputs
